// file: core/ffs_regs.svh
`ifndef FFS_REGS_SVH
`define FFS_REGS_SVH

// Array organisation: 256K words of four 9-bit lanes
`define FFS_ADDR_W   18
`define FFS_LANES    4
`define FFS_LANE_W   9
`define FFS_DATA_W   36
`define FFS_BYTE_W   8
`define FFS_PAR_POS  8
`define FFS_LOW_W    2

// Burst counter constants
`define FFS_CNT_ZERO 2'h0
`define FFS_CNT_ONE  2'h1

// Lane positions
`define FFS_LANE_A   0
`define FFS_LANE_B   1
`define FFS_LANE_C   2
`define FFS_LANE_D   3

`endif

// file: core/ffs_pkg.sv
`include "ffs_regs.svh"

package ffs_pkg;

    // Kind of cycle set when an address was loaded
    typedef enum logic [1:0] {
        CYC_IDLE,
        CYC_READ,
        CYC_WRITE
    } ffs_cycle_t;

    // Whole control state of the port
    typedef struct packed {
        ffs_cycle_t                 cyc;
        logic [`FFS_ADDR_W-1:0]     baseAddr;
        logic [`FFS_LOW_W-1:0]      burstCnt;
        logic                       wrPending;
        logic [`FFS_ADDR_W-1:0]     wrAddr;
        logic [`FFS_LANES-1:0]      wrLaneEn;
        logic [`FFS_DATA_W-1:0]     readData;
        logic                       drive;
    } ffs_state_t;

endpackage : ffs_pkg

// file: core/ffs_lane.sv
`timescale 1ns/1ps
`include "ffs_regs.svh"

module ffs_lane (
    // Organisation
    input  wire logic                    hasParity,
    // Lane pin value and pending write
    input  wire logic [`FFS_LANE_W-1:0]  laneIn,
    input  wire logic                    laneWrEn,
    input  wire logic                    pendHit,
    // Stored lane value
    input  wire logic [`FFS_LANE_W-1:0]  memLane,
    // Results
    output logic      [`FFS_LANE_W-1:0]  writeLane,
    output logic      [`FFS_LANE_W-1:0]  readLane
);

    // Ninth bit kept only in the wide organisation
    always_comb begin
        writeLane = laneIn;
        if (!hasParity) begin
            writeLane[`FFS_PAR_POS] = 1'b0;
        end
        // Read sees a write landing on the same edge
        readLane = (pendHit && laneWrEn) ? writeLane : memLane;
    end

endmodule : ffs_lane

// file: core/ffs_sram_port.sv
// The implementer's own choices: the address-and-strobe port.
`timescale 1ns/1ps
`include "ffs_regs.svh"

module ffs_sram_port #(
    parameter bit WideOrg = 1'b1
) (
    // Clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     rst_n,
    // Address
    input  wire logic [`FFS_ADDR_W-3:0]   syncAddressIn,
    input  wire logic                     burstAddrLsb1,
    input  wire logic                     burstAddrLsb0,
    // Cycle control
    input  wire logic                     chipSelectN,
    input  wire logic                     depthSelectLowN,
    input  wire logic                     depthSelectHigh,
    input  wire logic                     loadOrAdvance,
    input  wire logic                     readNotWrite,
    input  wire logic                     clkEnN,
    input  wire logic                     linearOrderN,
    // Asynchronous control
    input  wire logic                     outputEnableN,
    input  wire logic                     sleepRequest,
    // Lane write enables
    input  wire logic                     laneAWriteEnN,
    input  wire logic                     laneBWriteEnN,
    input  wire logic                     laneCWriteEnN,
    input  wire logic                     laneDWriteEnN,
    // Lane a pins
    input  wire logic [`FFS_BYTE_W-1:0]   byteLaneAIn,
    output logic      [`FFS_BYTE_W-1:0]   byteLaneAOut,
    output logic      [`FFS_BYTE_W-1:0]   byteLaneAOeN,
    input  wire logic                     laneAParityBitIn,
    output logic                          laneAParityBitOut,
    output logic                          laneAParityBitOeN,
    // Lane b pins
    input  wire logic [`FFS_BYTE_W-1:0]   byteLaneBIn,
    output logic      [`FFS_BYTE_W-1:0]   byteLaneBOut,
    output logic      [`FFS_BYTE_W-1:0]   byteLaneBOeN,
    input  wire logic                     laneBParityBitIn,
    output logic                          laneBParityBitOut,
    output logic                          laneBParityBitOeN,
    // Lane c pins
    input  wire logic [`FFS_BYTE_W-1:0]   byteLaneCIn,
    output logic      [`FFS_BYTE_W-1:0]   byteLaneCOut,
    output logic      [`FFS_BYTE_W-1:0]   byteLaneCOeN,
    input  wire logic                     laneCParityBitIn,
    output logic                          laneCParityBitOut,
    output logic                          laneCParityBitOeN,
    // Lane d pins
    input  wire logic [`FFS_BYTE_W-1:0]   byteLaneDIn,
    output logic      [`FFS_BYTE_W-1:0]   byteLaneDOut,
    output logic      [`FFS_BYTE_W-1:0]   byteLaneDOeN,
    input  wire logic                     laneDParityBitIn,
    output logic                          laneDParityBitOut,
    output logic                          laneDParityBitOeN
);

    ffs_pkg::ffs_state_t              stQ;
    ffs_pkg::ffs_state_t              stD;
    logic [`FFS_DATA_W-1:0]           memArr [2**`FFS_ADDR_W];
    logic                             run;
    logic                             selected;
    logic                             pinOffN;
    logic [`FFS_ADDR_W-1:0]           extAddr;
    logic [`FFS_ADDR_W-1:0]           advAddr;
    logic [`FFS_ADDR_W-1:0]           accAddr;
    logic [`FFS_LOW_W-1:0]            cntNext;
    logic [`FFS_LOW_W-1:0]            advLow;
    logic [`FFS_LOW_W-1:0]            cntQ;
    logic [`FFS_LANES-1:0]            laneEnN;
    logic                             pendHit;
    logic [`FFS_DATA_W-1:0]           memWord;
    logic [`FFS_LANE_W-1:0]           laneInArr [`FFS_LANES];
    logic [`FFS_LANE_W-1:0]           writeArr  [`FFS_LANES];
    logic [`FFS_LANE_W-1:0]           readArr   [`FFS_LANES];
    logic [`FFS_DATA_W-1:0]           readWord;

    // Edges count only when not stalled and not asleep
    assign run      = ~clkEnN & ~sleepRequest;
    assign selected = ~chipSelectN & ~depthSelectLowN & depthSelectHigh;

    // External address with its two low bits for the burst counter
    assign extAddr = {syncAddressIn, burstAddrLsb1, burstAddrLsb0};

    // Next burst address from loaded base and count
    assign cntNext = stQ.burstCnt + `FFS_CNT_ONE;
    assign advLow  = linearOrderN ? (stQ.baseAddr[`FFS_LOW_W-1:0] ^ cntNext)
                                  : (stQ.baseAddr[`FFS_LOW_W-1:0] + cntNext);
    assign advAddr = {stQ.baseAddr[`FFS_ADDR_W-1:`FFS_LOW_W], advLow};
    assign accAddr = loadOrAdvance ? advAddr : extAddr;
    assign cntQ    = stQ.burstCnt;

    // Lane enables and pins gathered per lane
    assign laneEnN[`FFS_LANE_A] = laneAWriteEnN;
    assign laneEnN[`FFS_LANE_B] = laneBWriteEnN;
    assign laneEnN[`FFS_LANE_C] = laneCWriteEnN;
    assign laneEnN[`FFS_LANE_D] = laneDWriteEnN;
    assign laneInArr[`FFS_LANE_A] = {laneAParityBitIn, byteLaneAIn};
    assign laneInArr[`FFS_LANE_B] = {laneBParityBitIn, byteLaneBIn};
    assign laneInArr[`FFS_LANE_C] = {laneCParityBitIn, byteLaneCIn};
    assign laneInArr[`FFS_LANE_D] = {laneDParityBitIn, byteLaneDIn};

    // Array word at the access address, with late write forwarding
    assign memWord = memArr[accAddr];
    assign pendHit = stQ.wrPending && (stQ.wrAddr == accAddr);

    // One merge slice per lane
    for (genvar i = 0; i < `FFS_LANES; i++) begin : g_lane
        ffs_lane ffs_lane_i (
            .hasParity (WideOrg),
            .laneIn    (laneInArr[i]),
            .laneWrEn  (stQ.wrLaneEn[i]),
            .pendHit   (pendHit),
            .memLane   (memWord[i*`FFS_LANE_W +: `FFS_LANE_W]),
            .writeLane (writeArr[i]),
            .readLane  (readArr[i])
        );
        assign readWord[i*`FFS_LANE_W +: `FFS_LANE_W] = readArr[i];
    end

    // Next state of the cycle sequencer
    always_comb begin
        stD = stQ;
        if (run) begin
            stD.wrPending = 1'b0;
            stD.drive     = 1'b0;
            if (!loadOrAdvance) begin
                stD.baseAddr = extAddr;
                stD.burstCnt = `FFS_CNT_ZERO;
                if (!selected) begin
                    stD.cyc = ffs_pkg::CYC_IDLE;
                end else if (readNotWrite) begin
                    stD.cyc = ffs_pkg::CYC_READ;
                end else begin
                    stD.cyc = ffs_pkg::CYC_WRITE;
                end
            end else if (stQ.cyc != ffs_pkg::CYC_IDLE) begin
                stD.burstCnt = cntNext;
            end
            unique case (stD.cyc)
                ffs_pkg::CYC_IDLE: begin
                end
                ffs_pkg::CYC_READ: begin
                    stD.drive    = 1'b1;
                    stD.readData = readWord;
                end
                ffs_pkg::CYC_WRITE: begin
                    stD.wrPending = 1'b1;
                    stD.wrAddr    = accAddr;
                    stD.wrLaneEn  = ~laneEnN;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            stQ <= '0;
        end else begin
            stQ <= stD;
        end
    end

    // Array write one edge after the address, only enabled lanes
    always_ff @(posedge sys_clk) begin
        if (run && stQ.wrPending) begin
            for (int i = 0; i < `FFS_LANES; i++) begin
                if (stQ.wrLaneEn[i]) begin
                    memArr[stQ.wrAddr][i*`FFS_LANE_W +: `FFS_LANE_W] <= writeArr[i];
                end
            end
        end
    end

    // Drivers off without the clock on output enable or sleep
    assign pinOffN = outputEnableN | sleepRequest | ~stQ.drive;

    // Lane outputs from the read register
    assign byteLaneAOut      = stQ.readData[`FFS_LANE_A*`FFS_LANE_W +: `FFS_BYTE_W];
    assign byteLaneBOut      = stQ.readData[`FFS_LANE_B*`FFS_LANE_W +: `FFS_BYTE_W];
    assign byteLaneCOut      = stQ.readData[`FFS_LANE_C*`FFS_LANE_W +: `FFS_BYTE_W];
    assign byteLaneDOut      = stQ.readData[`FFS_LANE_D*`FFS_LANE_W +: `FFS_BYTE_W];
    assign laneAParityBitOut = stQ.readData[`FFS_LANE_A*`FFS_LANE_W + `FFS_PAR_POS];
    assign laneBParityBitOut = stQ.readData[`FFS_LANE_B*`FFS_LANE_W + `FFS_PAR_POS];
    assign laneCParityBitOut = stQ.readData[`FFS_LANE_C*`FFS_LANE_W + `FFS_PAR_POS];
    assign laneDParityBitOut = stQ.readData[`FFS_LANE_D*`FFS_LANE_W + `FFS_PAR_POS];

    // Output enables, ninth bit never driven in the narrow organisation
    assign byteLaneAOeN      = {`FFS_BYTE_W{pinOffN}};
    assign byteLaneBOeN      = {`FFS_BYTE_W{pinOffN}};
    assign byteLaneCOeN      = {`FFS_BYTE_W{pinOffN}};
    assign byteLaneDOeN      = {`FFS_BYTE_W{pinOffN}};
    assign laneAParityBitOeN = pinOffN | ~WideOrg;
    assign laneBParityBitOeN = pinOffN | ~WideOrg;
    assign laneCParityBitOeN = pinOffN | ~WideOrg;
    assign laneDParityBitOeN = pinOffN | ~WideOrg;

    // Stall holds the whole state
    property p_stall_freeze;
        @(posedge sys_clk) disable iff (!rst_n)
        clkEnN |=> $stable(stQ);
    endproperty
    a_stall_freeze: assert property (p_stall_freeze)
        else $error("state moved during clock stall");

    // Sleep ignores every input except reset
    property p_sleep_hold;
        @(posedge sys_clk) disable iff (!rst_n)
        sleepRequest ##1 sleepRequest |-> $stable(stQ);
    endproperty
    a_sleep_hold: assert property (p_sleep_hold)
        else $error("state moved while asleep");

    // Sleep turns drivers off at once
    property p_sleep_off;
        @(posedge sys_clk) disable iff (!rst_n)
        sleepRequest |-> (byteLaneAOeN[0] && byteLaneDOeN[0] && laneBParityBitOeN);
    endproperty
    a_sleep_off: assert property (p_sleep_off)
        else $error("data driven while asleep");

    // Output enable high keeps drivers off
    property p_oe_gate;
        @(posedge sys_clk) disable iff (!rst_n)
        outputEnableN |-> (&byteLaneBOeN && &byteLaneCOeN && laneAParityBitOeN);
    endproperty
    a_oe_gate: assert property (p_oe_gate)
        else $error("data driven with output enable high");

    // Selected read load sets read cycle at the pin address
    property p_load_read;
        @(posedge sys_clk) disable iff (!rst_n)
        (run && !loadOrAdvance && selected && readNotWrite)
        |=> (stQ.cyc == ffs_pkg::CYC_READ) && stQ.drive
            && (stQ.baseAddr == $past(extAddr)) && (cntQ == `FFS_CNT_ZERO);
    endproperty
    a_load_read: assert property (p_load_read)
        else $error("read load did not start read cycle");

    // Any select false on load deselects
    property p_deselect;
        @(posedge sys_clk) disable iff (!rst_n)
        (run && !loadOrAdvance && !selected)
        |=> (stQ.cyc == ffs_pkg::CYC_IDLE) && !stQ.drive && !stQ.wrPending;
    endproperty
    a_deselect: assert property (p_deselect)
        else $error("load with select false did not deselect");

    // Advance steps the count and keeps cycle type
    property p_advance;
        @(posedge sys_clk) disable iff (!rst_n)
        (run && loadOrAdvance && stQ.cyc != ffs_pkg::CYC_IDLE)
        |=> (cntQ == $past(cntQ) + `FFS_CNT_ONE) && $stable(stQ.cyc);
    endproperty
    a_advance: assert property (p_advance)
        else $error("advance did not step burst or changed cycle type");

    // Four advances bring the count back to the start
    property p_wrap;
        @(posedge sys_clk) disable iff (!rst_n)
        (run && !loadOrAdvance && selected)
        ##1 (run && loadOrAdvance) [*4]
        |=> (cntQ == `FFS_CNT_ZERO);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("burst did not wrap after four accesses");

    // Write load leaves a pending write with inverted lane enables
    property p_write_late;
        @(posedge sys_clk) disable iff (!rst_n)
        (run && !loadOrAdvance && selected && !readNotWrite)
        |=> stQ.wrPending && (stQ.wrAddr == $past(extAddr))
            && (stQ.wrLaneEn == ~$past(laneEnN)) && !stQ.drive;
    endproperty
    a_write_late: assert property (p_write_late)
        else $error("write load did not set pending late write");

endmodule : ffs_sram_port

// file: verification/ffs_ctrl_model.sv
`timescale 1ns/1ps

// Controller side of the data pins: late write data and bus release
module ffs_ctrl_model (
    // Clock, reset and cycle pins as seen by the device
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        loadOrAdvance,
    input  wire logic        readNotWrite,
    input  wire logic        selected,
    input  wire logic        clkEnN,
    input  wire logic        sleepRequest,
    // Data meant for the beat addressed now
    input  wire logic [35:0] wrData,
    // Device data pins and resolved wire
    input  wire logic [35:0] devOut,
    input  wire logic [35:0] devOeN,
    output logic      [35:0] busIn
);
    logic        lastWr_q;
    logic        drive_q;
    logic [35:0] data_q;
    logic [35:0] rel_q;
    logic        runEdge;
    logic        isWr;

    // Beat kind is known at the address edge; advance keeps the loaded kind
    assign runEdge = !clkEnN && !sleepRequest;
    assign isWr    = loadOrAdvance ? lastWr_q : (selected && !readNotWrite);

    // Data follow one run edge after their address, held through stalls
    always_ff @(posedge sys_clk) begin
        rel_q <= ~busIn;
        if (!rst_n) begin
            lastWr_q <= 1'b0;
            drive_q  <= 1'b0;
            rel_q    <= 36'h0_0000_0000;
        end else if (runEdge) begin
            if (!loadOrAdvance) begin
                lastWr_q <= selected && !readNotWrite;
            end
            drive_q <= isWr;
            data_q  <= wrData;
        end
    end

    // Wire level: device, controller, else a pattern that keeps changing
    always_comb begin
        for (int k = 0; k < 36; k++) begin
            busIn[k] = !devOeN[k] ? devOut[k] : (drive_q ? data_q[k] : rel_q[k]);
        end
    end
endmodule : ffs_ctrl_model

// file: verification/ffs_sram_port_tb_top.sv
`timescale 1ns/1ps

// Self-checking bench of the synchronous port
module ffs_sram_port_tb_top;
    localparam logic [17:0] A0     = 18'h0_0100;
    localparam logic [17:0] A1     = 18'h0_0200;
    localparam logic [35:0] NoData = 36'h0_0000_0000;
    localparam logic [35:0] AllSet = 36'hf_ffff_ffff;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [15:0] syncAddressIn = 16'h0000;
    logic        burstAddrLsb1 = 1'b0;
    logic        burstAddrLsb0 = 1'b0;
    logic        chipSelectN = 1'b1;
    logic        depthSelectLowN = 1'b0;
    logic        depthSelectHigh = 1'b1;
    logic        loadOrAdvance = 1'b0;
    logic        readNotWrite = 1'b1;
    logic        clkEnN = 1'b0;
    logic        linearOrderN = 1'b0;
    logic        outputEnableN = 1'b0;
    logic        sleepRequest = 1'b0;
    logic [3:0]  laneWrEnN = 4'hf;
    logic [35:0] wrData = 36'h0_0000_0000;
    wire  [35:0] devOut;
    wire  [35:0] devOeN;
    wire  [35:0] busIn;
    wire         sel;
    int          n_mismatch = 0;
    int          n_compared = 0;
    int          cycles = 0;

    assign sel = !chipSelectN && !depthSelectLowN && depthSelectHigh;

    // Clock and hang guard
    always #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            test_done();
        end
    end

    ffs_sram_port #(.WideOrg(1'b1)) ffs_sram_port_i (
        .sys_clk(sys_clk), .rst_n(rst_n), .syncAddressIn(syncAddressIn),
        .burstAddrLsb1(burstAddrLsb1), .burstAddrLsb0(burstAddrLsb0),
        .chipSelectN(chipSelectN), .depthSelectLowN(depthSelectLowN),
        .depthSelectHigh(depthSelectHigh), .loadOrAdvance(loadOrAdvance),
        .readNotWrite(readNotWrite), .clkEnN(clkEnN), .linearOrderN(linearOrderN),
        .outputEnableN(outputEnableN), .sleepRequest(sleepRequest),
        .laneAWriteEnN(laneWrEnN[0]), .laneBWriteEnN(laneWrEnN[1]),
        .laneCWriteEnN(laneWrEnN[2]), .laneDWriteEnN(laneWrEnN[3]),
        .byteLaneAIn(busIn[7:0]), .byteLaneAOut(devOut[7:0]), .byteLaneAOeN(devOeN[7:0]),
        .laneAParityBitIn(busIn[8]), .laneAParityBitOut(devOut[8]),
        .laneAParityBitOeN(devOeN[8]),
        .byteLaneBIn(busIn[16:9]), .byteLaneBOut(devOut[16:9]), .byteLaneBOeN(devOeN[16:9]),
        .laneBParityBitIn(busIn[17]), .laneBParityBitOut(devOut[17]),
        .laneBParityBitOeN(devOeN[17]),
        .byteLaneCIn(busIn[25:18]), .byteLaneCOut(devOut[25:18]),
        .byteLaneCOeN(devOeN[25:18]), .laneCParityBitIn(busIn[26]),
        .laneCParityBitOut(devOut[26]), .laneCParityBitOeN(devOeN[26]),
        .byteLaneDIn(busIn[34:27]), .byteLaneDOut(devOut[34:27]),
        .byteLaneDOeN(devOeN[34:27]), .laneDParityBitIn(busIn[35]),
        .laneDParityBitOut(devOut[35]), .laneDParityBitOeN(devOeN[35])
    );

    ffs_ctrl_model ffs_ctrl_model_i (
        .sys_clk(sys_clk), .rst_n(rst_n), .loadOrAdvance(loadOrAdvance),
        .readNotWrite(readNotWrite), .selected(sel), .clkEnN(clkEnN),
        .sleepRequest(sleepRequest), .wrData(wrData), .devOut(devOut),
        .devOeN(devOeN), .busIn(busIn)
    );

    function automatic logic [17:0] at(input int i);
        return A0 + 18'(i);
    endfunction : at

    // Distinct word for every address, parity bits included
    function automatic logic [35:0] pat(input logic [17:0] a);
        return {a, ~a};
    endfunction : pat

    task automatic chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    // One cycle of commands; lane enables go with the address
    task automatic op(input logic ld, input logic rd, input logic cs, input logic [17:0] a,
                      input logic [3:0] wen, input logic [35:0] d);
        @(posedge sys_clk);
        loadOrAdvance <= !ld;
        readNotWrite  <= rd;
        chipSelectN   <= !cs;
        {syncAddressIn, burstAddrLsb1, burstAddrLsb0} <= a;
        laneWrEnN     <= wen;
        wrData        <= d;
    endtask : op

    // Flow-through read data standing after the last edge
    task automatic look(input logic [35:0] exp);
        #1;
        chk("read data", devOut, exp);
        chk("drive enables", devOeN, NoData);
    endtask : look

    task automatic t_fill();
        for (int i = 0; i < 4; i++) begin
            op(1'b1, 1'b0, 1'b1, at(i), 4'h0, pat(at(i)));
        end
        for (int i = 0; i < 4; i++) begin
            op(1'b1, 1'b1, 1'b1, at(i), 4'hf, NoData);
            if (i > 0) look(pat(at(i - 1)));
        end
        op(1'b1, 1'b1, 1'b0, A0, 4'hf, NoData);
        look(pat(at(3)));
        op(1'b1, 1'b1, 1'b0, A0, 4'hf, NoData);
        #1 chk("drive enables", devOeN, AllSet);
    endtask : t_fill

    // One lane at a time over a cleared word, read back at once
    task automatic t_lanes();
        for (int i = 0; i < 4; i++) begin
            op(1'b1, 1'b0, 1'b1, A1, 4'h0, NoData);
            op(1'b1, 1'b0, 1'b1, A1, ~(4'h1 << i), AllSet);
            op(1'b1, 1'b1, 1'b1, A1, 4'hf, NoData);
            op(1'b1, 1'b1, 1'b0, A1, 4'hf, NoData);
            look(36'h1ff << (9 * i));
        end
    endtask : t_lanes

    // Read burst; advance beats carry write, deselect and a stray address
    task automatic t_burst(input logic linN, input logic [1:0] s);
        logic [1:0] n;
        @(posedge sys_clk);
        linearOrderN <= linN;
        op(1'b1, 1'b1, 1'b1, at(int'(s)), 4'hf, NoData);
        for (int k = 0; k < 5; k++) begin
            op(1'b0, 1'b0, 1'b0, 18'h3_ffff, 4'h0, NoData);
            n = linN ? (s ^ 2'(k)) : (s + 2'(k));
            look(pat({A0[17:2], n}));
        end
        op(1'b1, 1'b1, 1'b0, A0, 4'hf, NoData);
    endtask : t_burst

    // Interleaved write burst; advance beats carry read, deselect, stray address
    task automatic t_wburst(input logic [1:0] s);
        logic [17:0] b;
        for (int k = 0; k < 4; k++) begin
            b = {A1[17:2], s ^ 2'(k)};
            op(k == 0, k != 0, k == 0, (k == 0) ? b : 18'h3_ffff, 4'h0, pat(b));
        end
        op(1'b1, 1'b1, 1'b0, A1, 4'hf, NoData);
        for (int k = 0; k < 4; k++) begin
            b = {A1[17:2], s ^ 2'(k)};
            op(1'b1, 1'b1, 1'b1, b, 4'hf, NoData);
            op(1'b1, 1'b1, 1'b0, A1, 4'hf, NoData);
            look(pat(b));
        end
    endtask : t_wburst

    // A write with any one select false is dropped
    task automatic t_desel();
        for (int j = 0; j < 3; j++) begin
            op(1'b1, 1'b0, j != 0, A0, 4'h0, NoData);
            depthSelectLowN <= (j == 1);
            depthSelectHigh <= (j != 2);
            op(1'b1, 1'b1, 1'b1, A0, 4'hf, NoData);
            depthSelectLowN <= 1'b0;
            depthSelectHigh <= 1'b1;
            #1 chk("drive enables", devOeN, AllSet);
            op(1'b1, 1'b1, 1'b0, A0, 4'hf, NoData);
            look(pat(A0));
        end
    endtask : t_desel

    // Stalled edges hold a read, and a write waits for its data edge
    task automatic t_stall();
        op(1'b1, 1'b1, 1'b1, at(1), 4'hf, NoData);
        op(1'b1, 1'b1, 1'b1, at(2), 4'hf, NoData);
        clkEnN <= 1'b1;
        repeat (3) begin
            look(pat(at(1)));
            @(posedge sys_clk);
        end
        clkEnN <= 1'b0;
        op(1'b1, 1'b1, 1'b0, A0, 4'hf, NoData);
        look(pat(at(2)));
        op(1'b1, 1'b0, 1'b1, at(3), 4'h0, 36'h5_a5a5_a5a5);
        op(1'b1, 1'b1, 1'b0, A0, 4'hf, NoData);
        clkEnN <= 1'b1;
        repeat (2) @(posedge sys_clk);
        clkEnN <= 1'b0;
        op(1'b1, 1'b1, 1'b1, at(3), 4'hf, NoData);
        op(1'b1, 1'b1, 1'b0, A0, 4'hf, NoData);
        look(36'h5_a5a5_a5a5);
    endtask : t_stall

    // Output enable gates the drivers with the state frozen
    task automatic t_oe();
        op(1'b1, 1'b1, 1'b1, A0, 4'hf, NoData);
        op(1'b1, 1'b1, 1'b0, A0, 4'hf, NoData);
        outputEnableN <= 1'b1;
        clkEnN        <= 1'b1;
        #1 chk("drive enables", devOeN, AllSet);
        @(posedge sys_clk);
        outputEnableN <= 1'b0;
        clkEnN        <= 1'b0;
        look(pat(A0));
    endtask : t_oe

    // Sleep drops the drivers, ignores a write, keeps the array
    task automatic t_sleep();
        op(1'b1, 1'b1, 1'b1, A0, 4'hf, NoData);
        op(1'b1, 1'b0, 1'b1, A0, 4'h0, NoData);
        sleepRequest <= 1'b1;
        #1 chk("drive enables", devOeN, AllSet);
        repeat (2) @(posedge sys_clk);
        op(1'b1, 1'b1, 1'b1, A0, 4'hf, NoData);
        sleepRequest <= 1'b0;
        op(1'b1, 1'b1, 1'b0, A0, 4'hf, NoData);
        look(pat(A0));
    endtask : t_sleep

    // Main sequence
    initial begin
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        #1;
        chk("drive enables", devOeN, AllSet);
        t_fill();
        t_lanes();
        t_burst(1'b0, 2'h3);
        t_burst(1'b1, 2'h1);
        t_wburst(2'h2);
        t_desel();
        t_stall();
        t_oe();
        t_sleep();
        test_done();
    end
endmodule : ffs_sram_port_tb_top
